// file: rtl/bkr_regs.sv
// Register bank of the step-down regulator, reached through a byte port.
// Assumes the I2C front end delivers addressed byte reads and writes.
`timescale 1ns/1ps
module bkr_regs #(
    parameter bit SLOW_RAMP_VARIANT = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_en_pin,
    input wire logic i_target_select_pin,
    input wire logic i_overtemp_event,
    input wire logic i_power_bad_event,
    output logic [7:0] o_rdata,
    output logic o_converter_on,
    output logic o_restart,
    output logic o_pwm_active,
    output logic o_pwm_during_slew,
    output logic o_discharge_enable,
    output logic [1:0] o_slew_rate_sel,
    output logic [6:0] o_target_code
);
    localparam logic [7:0] RST_CTRL = SLOW_RAMP_VARIANT ?
        bkr_pkg::RST_CTRL_SLOW : bkr_pkg::RST_CTRL_FAST;

    logic [7:0] vout_level_a;
    logic [7:0] vout_level_b;
    logic [7:0] regulator_control;
    logic [7:0] event_status;
    logic [7:0] ptr;
    logic en_pin_q;

    ////////////////////////////////////////////////////////////////////////
    // Address pointer and decode
    wire [7:0] cur_addr = i_start ? i_addr : ptr;
    wire acc = i_wr | i_rd;
    wire hit_a = cur_addr == bkr_pkg::ADDR_VOUT_A;
    wire hit_b = cur_addr == bkr_pkg::ADDR_VOUT_B;
    wire hit_c = cur_addr == bkr_pkg::ADDR_CTRL;
    wire hit_s = cur_addr == bkr_pkg::ADDR_STATUS;
    wire soft_rst = i_wr & hit_c & i_wdata[bkr_pkg::BIT_SOFT_RESET];
    wire en_rise = i_en_pin & ~en_pin_q;
    wire status_rd = i_rd & hit_s;
    wire [7:0] status_set = {3'h0, i_overtemp_event, 1'b0,
        i_power_bad_event, 2'h0} & bkr_pkg::STATUS_MASK;
    wire [7:0] next_rdata = hit_a ? vout_level_a :
                            hit_b ? vout_level_b :
                            hit_c ? (regulator_control & bkr_pkg::CTRL_RW_MASK) :
                            hit_s ? event_status :
                            bkr_pkg::READ_UNMAPPED;

    // Pointer advances after each data byte
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            ptr <= 8'h00;
        else if (acc)
            ptr <= cur_addr + 8'h01;
        else if (i_start)
            ptr <= i_addr;
    end

    ////////////////////////////////////////////////////////////////////////
    // Voltage registers, full eight bits writable
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || soft_rst)
        begin
            vout_level_a <= bkr_pkg::RST_VOUT_A;
            vout_level_b <= bkr_pkg::RST_VOUT_B;
        end
        else if (i_wr)
        begin
            if (hit_a)
                vout_level_a <= i_wdata;
            if (hit_b)
                vout_level_b <= i_wdata;
        end
    end

    // Control register; write-only reset bit never stored
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || soft_rst)
            regulator_control <= RST_CTRL;
        else if (i_wr && hit_c)
            regulator_control <= i_wdata & bkr_pkg::CTRL_RW_MASK;
        else if (en_rise)
            regulator_control[bkr_pkg::BIT_DISCHARGE] <=
                RST_CTRL[bkr_pkg::BIT_DISCHARGE];
    end

    // Sticky status flags; set wins over clear on read
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || soft_rst)
            event_status <= bkr_pkg::RST_STATUS;
        else if (status_rd)
            event_status <= status_set;
        else
            event_status <= event_status | status_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs registered
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_rdata <= 8'h00;
            o_restart <= 1'b0;
        end
        else
        begin
            o_restart <= soft_rst;
            if (i_rd)
                o_rdata <= next_rdata;
        end
    end

    // Enable pin history, kept out of reset so a high pin gives no false edge
    always_ff @(posedge i_mclk)
    begin
        en_pin_q <= i_en_pin;
    end

    wire sel_b = i_target_select_pin;
    wire [6:0] next_code = sel_b ? vout_level_b[6:0] : vout_level_a[6:0];
    wire next_pwm = regulator_control[bkr_pkg::BIT_LIGHT_PWM] |
        (sel_b & vout_level_b[bkr_pkg::BIT_OVERRIDE]);

    // Steering outputs to the analog control
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_target_code <= bkr_pkg::RST_VOUT_A[6:0];
            o_converter_on <= 1'b0;
            o_pwm_active <= 1'b0;
            o_pwm_during_slew <= 1'b0;
            o_discharge_enable <= 1'b0;
            o_slew_rate_sel <= 2'h0;
        end
        else
        begin
            o_target_code <= next_code;
            o_converter_on <= regulator_control[bkr_pkg::BIT_ENABLE]
                & ~soft_rst;
            o_pwm_active <= next_pwm;
            o_pwm_during_slew <= regulator_control[bkr_pkg::BIT_PWM_SLEW];
            o_discharge_enable <= regulator_control[bkr_pkg::BIT_DISCHARGE];
            o_slew_rate_sel <= regulator_control[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the byte port
    unmapped_read_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        i_rd && !(hit_a || hit_b || hit_c || hit_s)
        |=> o_rdata == bkr_pkg::READ_UNMAPPED)
        else $error("unmapped read not all ones");
    ptr_advance_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        acc |=> ptr == $past(cur_addr) + 8'h01)
        else $error("pointer did not advance");
    ctrl_read_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        i_rd && hit_c |=> !o_rdata[bkr_pkg::BIT_SOFT_RESET])
        else $error("reset bit read back");

    // Checks on soft reset and defaults
    soft_reset_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        soft_rst |=> vout_level_a == bkr_pkg::RST_VOUT_A
        && vout_level_b == bkr_pkg::RST_VOUT_B && o_restart)
        else $error("soft reset failed");
    ctrl_default_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        soft_rst |=> regulator_control == RST_CTRL)
        else $error("control default not restored");

    // Checks on sticky status flags
    status_ro_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        i_wr && hit_s
        |=> event_status == ($past(event_status) | $past(status_set)))
        else $error("status changed by write");
    status_clear_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        status_rd && status_set == 8'h00 && !soft_rst
        |=> event_status == bkr_pkg::RST_STATUS)
        else $error("status not cleared by read");
    status_hold_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        !status_rd && !soft_rst
        |=> (event_status & $past(event_status)) == $past(event_status))
        else $error("status flag dropped before read");

    // Checks on steering outputs
    discharge_pin_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        en_rise && !i_wr |=> ##1 o_discharge_enable)
        else $error("enable edge kept discharge off");
    override_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        sel_b && vout_level_b[bkr_pkg::BIT_OVERRIDE] |=> o_pwm_active)
        else $error("override ignored");
    light_pwm_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        regulator_control[bkr_pkg::BIT_LIGHT_PWM] |=> o_pwm_active)
        else $error("light load pwm ignored");
    enable_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        !regulator_control[bkr_pkg::BIT_ENABLE] |=> !o_converter_on)
        else $error("converter on while disabled");
    code_b_sel_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        sel_b |=> o_target_code == $past(vout_level_b[6:0]))
        else $error("second target code not steered");
    code_a_sel_a: assert property (
        @(posedge i_mclk) disable iff (i_srst)
        !sel_b |=> o_target_code == $past(vout_level_a[6:0]))
        else $error("first target code not steered");

    // Main scenarios reached
    multi_wr_c: cover property (@(posedge i_mclk) i_wr ##1 i_wr ##1 i_wr);
    status_rd_c: cover property (@(posedge i_mclk) status_rd);
    soft_rst_c: cover property (@(posedge i_mclk) soft_rst);
    pin_edge_c: cover property (@(posedge i_mclk) en_rise);
    override_c: cover property (@(posedge i_mclk)
        sel_b && vout_level_b[bkr_pkg::BIT_OVERRIDE]);
endmodule : bkr_regs

// file: rtl/bkr_pkg.sv
// Constants for the regulator control register bank behind an I2C slave.
// Assumes a byte-level register port: address, write strobe, read strobe.
// Contract
// - All registers are eight bits, bit 0 least significant.
// - Slave answers at seven-bit address 0x40; master must use it.
// - Seven-bit code gives output of code times 12.5 mV plus 0.4 V.
// - First voltage register at 0x01 resets to 0x10; bit 7 reserved RW.
// - Second voltage register at 0x02 resets to 0x38, override cleared.
// - Bit 7 of second register forces PWM while that target is selected.
// - Writing control bit 7 resets all registers and restarts converter.
// - Control bit 6 forces PWM during voltage change when set.
// - Control bit 5 clear disables converter; set restarts without delay.
// - Control bit 4 chooses power-save (0) or forced PWM (1).
// - Control bit 3 enables output discharge for next disable cycle.
// - Control bits 1:0 pick slew 10, 5, 1 or 0.1 mV per microsecond.
// - Control register at 0x03 resets to 0x68 or 0x6B by variant.
// - Reads of unmapped addresses return 0xFF.
// - Multi-byte access advances the register address after each byte.
// - Rising edge on enable pin restores the discharge enable default.
// - Status flags hold until read or reset, then clear to zero; a flag whose event comes in the reading cycle stays set.
package bkr_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h40;
    localparam logic [7:0] ADDR_VOUT_A = 8'h01;
    localparam logic [7:0] ADDR_VOUT_B = 8'h02;
    localparam logic [7:0] ADDR_CTRL = 8'h03;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] RST_VOUT_A = 8'h10;
    localparam logic [7:0] RST_VOUT_B = 8'h38;
    localparam logic [7:0] RST_CTRL_FAST = 8'h68;
    localparam logic [7:0] RST_CTRL_SLOW = 8'h6B;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'hFF;
    localparam int BIT_OVERRIDE = 7;
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_PWM_SLEW = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_LIGHT_PWM = 4;
    localparam int BIT_DISCHARGE = 3;
    localparam int BIT_OVERTEMP = 4;
    localparam int BIT_POWER_BAD = 2;
    localparam logic [7:0] STATUS_MASK = 8'h14;
    localparam logic [7:0] CTRL_RW_MASK = 8'h7F;
endpackage : bkr_pkg

// file: testbench/bkr_host.sv
// Byte-port host model standing in for the I2C front end.
// Assumes the bank samples strobes on rising i_mclk.
`timescale 1ns/1ps
module bkr_host (
    input wire logic i_mclk,
    output logic o_start,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    initial {o_start, o_addr, o_wr, o_rd, o_wdata} = '0;
    // One byte access; address only with a start, else pointer steps
    task automatic acc(input bit st, input bit w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge i_mclk);
        o_start <= st;
        o_addr <= st ? a : ~o_addr;
        o_wr <= w;
        o_rd <= !w;
        o_wdata <= w ? d : ~o_wdata;
    endtask : acc
    // Release strobes; unqualified lines keep toggling
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge i_mclk);
            {o_start, o_wr, o_rd} <= '0;
            o_addr <= ~o_addr;
            o_wdata <= ~o_wdata;
        end
    endtask : idle
endmodule : bkr_host

// file: testbench/tb_bkr_regs.sv
// Self-checking bench for the regulator register bank.
// Assumes the host model drives the byte port.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
error_cnt++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_buck_regulator_control_registers;
    logic i_mclk = 0, i_srst = 1, en = 0, sel = 0, ot = 0, pb = 0, rd_d = 0;
    logic st, wr, rd, pwm, slw, on, dis, rs;
    logic [7:0] ad, wd, rdat, a, b, c, q[$];
    logic [6:0] code;
    logic [1:0] sr;
    int error_cnt = 0, comparisons = 0, rst_seen = 0, seed = 32'hFFB1;
    bkr_host u_host (.i_mclk(i_mclk), .o_start(st), .o_addr(ad), .o_wr(wr),
        .o_rd(rd), .o_wdata(wd));
    bkr_regs u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_start(st),
        .i_addr(ad), .i_wr(wr), .i_rd(rd), .i_wdata(wd), .i_en_pin(en),
        .i_target_select_pin(sel), .i_overtemp_event(ot),
        .i_power_bad_event(pb), .o_rdata(rdat), .o_converter_on(on),
        .o_restart(rs), .o_pwm_active(pwm), .o_pwm_during_slew(slw),
        .o_discharge_enable(dis), .o_slew_rate_sel(sr), .o_target_code(code));
    // Clock
    initial forever #50 i_mclk = ~i_mclk;
    // Read monitor compares against the oldest noted value
    always @(posedge i_mclk) rd_d <= rd;
    always @(negedge i_mclk)
    begin
        if (rd_d) `CHK("rdata", q.pop_front(), rdat)
        if (rs) rst_seen++;
    end
    // Read with new address, then next-pointer read
    task automatic rda(input logic [7:0] ra, input logic [7:0] e);
        q.push_back(e);
        u_host.acc(1, 0, ra, 8'h00);
    endtask : rda
    task automatic rdn(input logic [7:0] e);
        q.push_back(e);
        u_host.acc(0, 0, 8'h00, 8'h00);
    endtask : rdn
    task automatic wra(input logic [7:0] wa, input logic [7:0] d);
        u_host.acc(1, 1, wa, d);
        u_host.idle(3);
    endtask : wra
    task automatic stop_test;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // Watchdog
    initial
    begin
        #(3000 * 100);
        error_cnt++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        a = 8'($random(seed));
        b = 8'($random(seed));
        repeat (8) @(posedge i_mclk);
        i_srst <= 0;
        rda(8'h01, 8'h10);
        rdn(8'h38);
        rdn(8'h6B);
        rdn(8'hFF);
        rdn(8'h00);
        u_host.acc(1, 1, 8'h01, a);
        u_host.acc(0, 1, 8'h00, b);
        u_host.idle(3);
        `CHK("code_a", a[6:0], code)
        sel <= 1;
        u_host.idle(3);
        `CHK("code_b", b[6:0], code)
        `CHK("override", b[7], pwm)
        for (int k = 0; k < 4; k++)
        begin
            c = {1'b0, 7'($random(seed))};
            c[1:0] = 2'(k);
            wra(8'h03, c);
            `CHK("slew", c[1:0], sr)
            `CHK("slew_pwm", c[6], slw)
            `CHK("conv_on", c[5], on)
            `CHK("light_pwm", c[4] | b[7], pwm)
            `CHK("discharge", c[3], dis)
            rda(8'h03, c);
        end
        rda(8'h10, 8'hFF);
        u_host.acc(1, 1, 8'h06, a);
        rdn(8'hFF);
        u_host.idle(1);
        c = 8'($random(seed));
        ot <= 1;
        pb <= c[0];
        @(posedge i_mclk);
        {ot, pb} <= 2'b00;
        wra(8'h05, 8'hFF);
        rda(8'h05, {3'h0, 1'b1, 1'b0, c[0], 2'h0});
        rda(8'h05, 8'h00);
        wra(8'h03, 8'h00);
        en <= 1;
        u_host.idle(3);
        `CHK("pin_discharge", 1'b1, dis)
        wra(8'h03, 8'h80);
        rda(8'h01, 8'h10);
        rdn(8'h38);
        rdn(8'h6B);
        u_host.idle(3);
        `CHK("restart", 1, rst_seen)
        stop_test();
    end
endmodule : tb_buck_regulator_control_registers
